// File: bpl_params.svh
// Offsets, reset values, field positions and timing counts of the burst and peak limit block
`ifndef BPL_PARAMS_SVH
`define BPL_PARAMS_SVH

// Clock rate in MHz
`define BPL_CLK_MHZ      250

// Register byte offsets
`define BPL_OFS_CTRL     8'h00
`define BPL_OFS_STAT     8'h04
`define BPL_OFS_TON      8'h08
`define BPL_OFS_TPER     8'h0c

// Control register fields and reset value
`define BPL_CTRL_PWM_EN  0
`define BPL_CTRL_BURST_EN 1
`define BPL_CTRL_RST     32'h0000_0003

// Status register fields
`define BPL_ST_OPT_LSB   0
`define BPL_ST_ISO       2
`define BPL_ST_BURST_LSB 3
`define BPL_ST_START_LSB 5
`define BPL_ST_GATE      7
`define BPL_ST_LIM_LSB   8

// Turn-on blanking time in ns, rounded up to cycles
`define BPL_LEB_NS       220
`define BPL_LEB_CYC      ((`BPL_LEB_NS * `BPL_CLK_MHZ + 999) / 1000)

// Burst entry blanking time in us, in cycles
`define BPL_BEB_US       20
`define BPL_BEB_CYC      (`BPL_BEB_US * `BPL_CLK_MHZ)

// Duty split between the two compensation curves, 0.40
`define BPL_DUTY_NUM     40
`define BPL_DUTY_DEN     100

// Analog references in mV handed to the comparator DACs
`define BPL_LIM_LOW_MV   12'h0dc
`define BPL_LIM_HIGH_MV  12'h10e
`define BPL_ENT_LOW_MV   12'h3a2
`define BPL_ENT_HIGH_MV  12'h406

`endif

// File: bpl_pkg.sv
// Types shared by the burst and peak limit block
package bpl_pkg;

   // Startup and option sensing sequence
   typedef enum logic [1:0] {
      BPL_SU_OFF   = 2'b00,
      BPL_SU_SENSE = 2'b01,
      BPL_SU_RUN   = 2'b10
   } bpl_start_e;

   // Light-load burst states
   typedef enum logic [1:0] {
      BPL_BM_NORMAL = 2'b00,
      BPL_BM_PAUSE  = 2'b01,
      BPL_BM_SWITCH = 2'b10
   } bpl_burst_e;

   // Burst options decoded at startup
   typedef enum logic [1:0] {
      BPL_OPT_NONE = 2'b01,
      BPL_OPT_LOW  = 2'b10,
      BPL_OPT_HIGH = 2'b11
   } bpl_opt_e;

   // Which peak limit the current comparator uses
   typedef enum logic [1:0] {
      BPL_LIM_LOW_DUTY  = 2'b00,
      BPL_LIM_HIGH_DUTY = 2'b01,
      BPL_LIM_BURST     = 2'b10
   } bpl_lim_e;

   // Feedback pin comparator results
   typedef struct packed {
      logic below_entry;       // Below selected entry level
      logic above_resume;      // Above burst_resume_level
      logic below_pause;       // At or below burst_pause_level
      logic above_exit;        // Above burst_exit_level
      logic above_band_low;    // Above option_band_low_edge
      logic above_band_high;   // Above option_band_high_edge
   } bpl_fb_cmp_s;

   // Supply threshold comparator results
   typedef struct packed {
      logic above_sense_start; // Supply above 4.44 V
      logic at_turn_on;        // Supply reached turn-on, 16.0 V
   } bpl_supply_s;

endpackage : bpl_pkg

// File: bpl_ctrl.sv
// Peak limit, light-load burst and startup option logic with AHB-Lite registers
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "bpl_params.svh"

// How it works
// - Current sense over limit ends gate immediately
// - Ignore current sense during turn-on blanking
// - Two limit curves, split at 0.40 duty
// - Reduced delay compensation during burst
// - Enter burst after full entry blanking
// - Paused burst resumes above resume level
// - Switching burst pauses at pause level
// - Burst limit 0.22 V low, 0.27 V high
// - Above 2.73 V leave burst, restore limit
// - Decode feedback level into three options
// - Entry 0.93 V/1.03 V; option 1 none
// - Preset option 3 at first startup
// - Sense window opens resistor, enables source
// - Latch option, source off, resistor back
// - Error pin above 0.2 V selects non-isolated
// - Isolated: error amp off feedback pin
// - Non-isolated: error amp drives feedback pin
// - Turn-on threshold 16.0 V ends sensing
module bpl_ctrl
   import bpl_pkg::*;
#(
   parameter logic [15:0] ENTRY_BLANK_CYC = 16'(`BPL_BEB_CYC)
) (
   input  wire logic        core_clk,             // Oscillator clock, 250 MHz
   input  wire logic        rstn,                 // Supply undervoltage reset
   input  wire logic        hsel,                 // AHB slave select
   input  wire logic [31:0] haddr,                // AHB address
   input  wire logic [1:0]  htrans,               // AHB transfer type
   input  wire logic        hwrite,               // AHB write
   input  wire logic [2:0]  hsize,                // AHB size, words only
   input  wire logic [31:0] hwdata,               // AHB write data
   input  wire logic        hready,               // AHB bus ready
   output logic             hreadyout,            // Slave ready
   output logic             hresp,                // Always OKAY
   output logic [31:0]      hrdata,               // Read data
   input  wire logic        cycle_start,          // Oscillator switch-on pulse
   input  wire logic        pwm_off,              // PWM or max duty turn-off
   input  wire logic        cs_over_limit,        // Current sense above limit
   input  bpl_fb_cmp_s      fb_cmp,               // Feedback comparators
   input  bpl_supply_s      supply,               // Supply comparators
   input  wire logic        error_amp_above_bias, // Error pin above 0.2 V
   output logic             gate_en,              // Gate drive enable
   output bpl_lim_e         limit_sel,            // Active peak limit curve
   output logic             prop_comp_reduced,    // Burst delay compensation
   output logic [11:0]      burst_peak_limit,     // Burst limit in mV
   output logic [11:0]      entry_level,          // Burst entry level in mV
   output logic             loop_resistor_switch, // Feedback resistor closed
   output logic             sel_current_en,       // Selection source on
   output logic             error_amp_connect,    // Error amp on feedback pin
   output logic             bias_en               // Internal bias running
);

   // Saturating counter step, shared by the entry blanking, on-time and period counters
   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
   endfunction : sat_inc

   bpl_start_e  start_reg;
   bpl_start_e  start_next;
   bpl_burst_e  burst_reg;
   bpl_burst_e  burst_next;
   bpl_opt_e    opt_reg;
   logic        iso_reg;
   logic [31:0] ctrl_reg;
   logic        gate_reg;
   logic [7:0]  leb_reg;
   logic [15:0] ton_reg;
   logic [15:0] per_reg;
   logic [15:0] ton_last_reg;
   logic [15:0] per_last_reg;
   logic [15:0] beb_reg;
   logic [31:0] hrdata_reg;
   logic [7:0]  addr_reg;
   logic        wr_pend_reg;

   wire logic        run;
   wire logic        sensing;
   wire logic        in_burst;
   wire logic        pwm_active;
   wire logic        blank_done;
   wire logic        cs_trip;
   wire logic        gate_end;
   wire logic        duty_high;
   wire logic        may_burst;
   wire logic        beb_done;
   wire logic        bus_take;
   wire logic [7:0]  addr_ofs;
   wire logic [31:0] stat_word;
   wire logic [31:0] rd_word;
   wire bpl_opt_e    opt_sensed;

   // Sequence decode
   assign run      = (start_reg == BPL_SU_RUN);
   assign sensing  = (start_reg == BPL_SU_SENSE);
   assign in_burst = (burst_reg != BPL_BM_NORMAL);

   // Gate may switch while running with PWM enabled, unless a burst pause holds the pulse-width section off
   assign pwm_active = run && ctrl_reg[`BPL_CTRL_PWM_EN]
                       && (burst_reg != BPL_BM_PAUSE);

   // Blanking masks the turn-on spike before the comparator is trusted
   assign blank_done = (leb_reg == 8'h00);
   assign cs_trip    = gate_reg && blank_done && cs_over_limit;
   assign gate_end   = cs_trip || pwm_off || !pwm_active;

   // Gate drops in the same cycle as the trip, not one edge later
   assign gate_en = gate_reg && !cs_trip && pwm_active;

   // On-time against 0.40 of the last period picks the curve
   assign duty_high = ({8'h00, ton_reg} * 24'(`BPL_DUTY_DEN))
                      > ({8'h00, per_last_reg} * 24'(`BPL_DUTY_NUM));

   // Exit comparator restores the normal limit without waiting a clock
   assign limit_sel = (in_burst && !fb_cmp.above_exit) ? BPL_LIM_BURST
                    : (duty_high ? BPL_LIM_HIGH_DUTY
                                 : BPL_LIM_LOW_DUTY);
   assign prop_comp_reduced = in_burst;

   // Option dependent analog levels
   assign burst_peak_limit = (opt_reg == BPL_OPT_LOW) ? `BPL_LIM_LOW_MV
                                                      : `BPL_LIM_HIGH_MV;
   assign entry_level = (opt_reg == BPL_OPT_LOW) ? `BPL_ENT_LOW_MV
                                                 : `BPL_ENT_HIGH_MV;

   // Band edges sorted into three options
   assign opt_sensed = fb_cmp.above_band_high ? BPL_OPT_HIGH
                     : (fb_cmp.above_band_low ? BPL_OPT_LOW
                                              : BPL_OPT_NONE);

   // Sensing window switches, selection source replaces the resistor
   assign loop_resistor_switch = !sensing;
   assign sel_current_en       = sensing;

   // Error amp reaches feedback pin only when non-isolated
   assign error_amp_connect = run && !iso_reg;
   assign bias_en = run && (burst_reg != BPL_BM_PAUSE);

   // Burst entry allowed only for options 2 and 3
   assign may_burst = run && ctrl_reg[`BPL_CTRL_BURST_EN]
                      && (opt_reg != BPL_OPT_NONE);
   assign beb_done  = (beb_reg >= ENTRY_BLANK_CYC - 16'h0001);

   // Startup sequence; turn-on ends the sensing window
   always_comb begin
      start_next = start_reg;
      case (start_reg)
         BPL_SU_OFF: begin
            if (supply.above_sense_start)
               start_next = BPL_SU_SENSE;
         end
         BPL_SU_SENSE: begin
            if (supply.at_turn_on)
               start_next = BPL_SU_RUN;
            else if (!supply.above_sense_start)
               start_next = BPL_SU_OFF;
         end
         BPL_SU_RUN: start_next = BPL_SU_RUN;
         default:    start_next = BPL_SU_OFF;
      endcase
   end

   // Burst state; exit wins over every other move
   always_comb begin
      burst_next = burst_reg;
      case (burst_reg)
         BPL_BM_NORMAL: begin
            if (may_burst && fb_cmp.below_entry && beb_done)
               burst_next = BPL_BM_PAUSE;
         end
         BPL_BM_PAUSE: begin
            if (fb_cmp.above_exit)
               burst_next = BPL_BM_NORMAL;
            else if (fb_cmp.above_resume)
               burst_next = BPL_BM_SWITCH;
         end
         BPL_BM_SWITCH: begin
            if (fb_cmp.above_exit)
               burst_next = BPL_BM_NORMAL;
            else if (fb_cmp.below_pause)
               burst_next = BPL_BM_PAUSE;
         end
         default: burst_next = BPL_BM_NORMAL;
      endcase
   end

   // State registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         start_reg <= BPL_SU_OFF;
         burst_reg <= BPL_BM_NORMAL;
      end else begin
         start_reg <= start_next;
         burst_reg <= burst_next;
      end
   end

   // Option preset to 3, latched once turn-on is seen
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         opt_reg <= BPL_OPT_HIGH;
         iso_reg <= 1'b1;
      end else if (sensing && supply.at_turn_on) begin
         opt_reg <= opt_sensed;
         iso_reg <= !error_amp_above_bias;
      end
   end

   // Entry blanking counts only while feedback stays below entry
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         beb_reg <= 16'h0000;
      else if (burst_reg == BPL_BM_NORMAL && may_burst && fb_cmp.below_entry)
         beb_reg <= sat_inc(beb_reg);
      else
         beb_reg <= 16'h0000;
   end

   // Gate pulse and turn-on blanking
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         gate_reg <= 1'b0;
         leb_reg  <= 8'h00;
      end else if (cycle_start && pwm_active) begin
         gate_reg <= 1'b1;
         leb_reg  <= 8'(`BPL_LEB_CYC);
      end else begin
         if (gate_end)
            gate_reg <= 1'b0;
         if (!blank_done)
            leb_reg <= leb_reg - 8'h01;
      end
   end

   // On-time and period measurement for the curve choice
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ton_reg      <= 16'h0000;
         per_reg      <= 16'h0000;
         ton_last_reg <= 16'h0000;
         per_last_reg <= 16'hffff;
      end else if (cycle_start) begin
         ton_reg      <= 16'h0000;
         per_reg      <= 16'h0001;
         per_last_reg <= per_reg;
         ton_last_reg <= ton_reg;
      end else begin
         per_reg <= sat_inc(per_reg);
         if (gate_en)
            ton_reg <= sat_inc(ton_reg);
      end
   end

   // Bus address decode; zero wait states, always OKAY
   assign bus_take  = hsel && htrans[1] && hready;
   assign addr_ofs  = haddr[7:0];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

   // Status word shows block state
   assign stat_word = {22'h0, limit_sel, gate_en, start_reg,
                       burst_reg, iso_reg, opt_reg};

   // Unmapped or misaligned offsets read as zero
   assign rd_word = (haddr[31:8] != 24'h000000) ? 32'h0000_0000
                  : (addr_ofs == `BPL_OFS_CTRL) ? ctrl_reg
                  : (addr_ofs == `BPL_OFS_STAT) ? stat_word
                  : (addr_ofs == `BPL_OFS_TON)  ? {16'h0000, ton_last_reg}
                  : (addr_ofs == `BPL_OFS_TPER) ? {16'h0000, per_last_reg}
                  : 32'h0000_0000;

   // Address phase capture; read data is registered for the data phase
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
         hrdata_reg  <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= bus_take && hwrite && (haddr[31:8] == 24'h000000);
         addr_reg    <= addr_ofs;
         if (bus_take && !hwrite)
            hrdata_reg <= rd_word;
      end
   end

   // Only the control word is writable; hsize is not checked, words only
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         ctrl_reg <= `BPL_CTRL_RST;
      else if (wr_pend_reg && addr_reg == `BPL_OFS_CTRL)
         ctrl_reg <= {30'h0, hwdata[1:0]};
   end

endmodule : bpl_ctrl

// File: bpl_ctrl_monitor.sv
// Assertion checker for the burst and peak limit block
`timescale 1ns/100ps
module bpl_ctrl_monitor
   import bpl_pkg::*;
#(
   parameter logic [15:0] ENTRY_BLANK_CYC = 16'd5000
) (
   input wire logic        core_clk,             // Clock
   input wire logic        rstn,                 // Reset
   input wire logic        cycle_start,          // Switch-on
   input wire logic        pwm_off,              // Turn-off
   input wire logic        cs_over_limit,        // Over limit
   input bpl_fb_cmp_s      fb_cmp,               // Feedback
   input bpl_supply_s      supply,               // Supply
   input wire logic        error_amp_above_bias, // Error pin
   input wire logic        gate_en,              // Gate
   input bpl_lim_e         limit_sel,            // Limit curve
   input wire logic        prop_comp_reduced,    // Burst comp
   input wire logic [11:0] burst_peak_limit,     // Burst limit
   input wire logic [11:0] entry_level,          // Entry level
   input wire logic        loop_resistor_switch, // Resistor
   input wire logic        sel_current_en,       // Source
   input wire logic        error_amp_connect,    // Amp link
   input wire logic        bias_en               // Bias
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // Cycles since switch-on, and run length of low feedback
   logic [7:0]  blk_cnt;
   logic [15:0] low_cnt;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         blk_cnt <= 8'hff;
         low_cnt <= 16'h0000;
      end else begin
         blk_cnt <= cycle_start ? 8'h01 : blk_cnt + {7'h00, blk_cnt != 8'hff};
         low_cnt <= fb_cmp.below_entry ? low_cnt + 16'h0001 : 16'h0000;
      end
   end

   // Guards skip burst moves, which may end a pulse lawfully
   property p_cs_trip; (blk_cnt > 8'd55 && cs_over_limit) |-> !gate_en; endproperty
   a_cs_trip: assert property (p_cs_trip) else $error("gate kept over limit");
   property p_blank;
      (blk_cnt inside {[1:54]} && gate_en && !prop_comp_reduced && !fb_cmp.below_entry)
         |=> (gate_en || pwm_off);
   endproperty
   a_blank: assert property (p_blank) else $error("gate ended in blanking");
   property p_burst_lim; (prop_comp_reduced && !fb_cmp.above_exit) |-> limit_sel == BPL_LIM_BURST;
   endproperty
   a_burst_lim: assert property (p_burst_lim) else $error("burst limit not used");
   property p_exit;
      fb_cmp.above_exit |-> (limit_sel != BPL_LIM_BURST) ##1 !prop_comp_reduced;
   endproperty
   a_exit: assert property (p_exit) else $error("burst not left");
   property p_entry; $rose(prop_comp_reduced) |-> low_cnt >= ENTRY_BLANK_CYC; endproperty
   a_entry: assert property (p_entry) else $error("burst entered early");
   property p_resume;
      (prop_comp_reduced && !bias_en && fb_cmp.above_resume && !fb_cmp.above_exit) |=> bias_en;
   endproperty
   a_resume: assert property (p_resume) else $error("burst not resumed");
   property p_pause;
      (prop_comp_reduced && bias_en && fb_cmp.below_pause && !fb_cmp.above_exit)
         |=> (!bias_en && !gate_en);
   endproperty
   a_pause: assert property (p_pause) else $error("burst not paused");
   property p_opt; burst_peak_limit == ((entry_level == 12'h3a2) ? 12'h0dc : 12'h10e); endproperty
   a_opt: assert property (p_opt) else $error("option levels differ");
   property p_sense; sel_current_en |-> (!loop_resistor_switch && !error_amp_connect); endproperty
   a_sense: assert property (p_sense) else $error("sense window wrong");
   property p_latch;
      (sel_current_en && supply.at_turn_on) |=> (!sel_current_en && loop_resistor_switch
         && error_amp_connect == $past(error_amp_above_bias));
   endproperty
   a_latch: assert property (p_latch) else $error("latch wrong");
   property p_hold; $changed(error_amp_connect) |-> $past(sel_current_en); endproperty
   a_hold: assert property (p_hold) else $error("config changed late");

   // Main scenarios reached
   c_burst: cover property ($rose(prop_comp_reduced));
   c_trip: cover property (blk_cnt > 8'd55 && cs_over_limit);
   c_sense: cover property (sel_current_en && supply.at_turn_on);
endmodule : bpl_ctrl_monitor

bind bpl_ctrl bpl_ctrl_monitor #(.ENTRY_BLANK_CYC(ENTRY_BLANK_CYC)) bpl_ctrl_monitor_i (
   .core_clk, .rstn, .cycle_start, .pwm_off, .cs_over_limit, .fb_cmp, .supply,
   .error_amp_above_bias, .gate_en, .limit_sel, .prop_comp_reduced, .burst_peak_limit,
   .entry_level, .loop_resistor_switch, .sel_current_en, .error_amp_connect, .bias_en);

// File: bpl_plant.sv
// Switch, sense resistor and feedback network model
`timescale 1ns/100ps
module bpl_plant
   import bpl_pkg::*;
#(
   parameter int BAND_LO_MV = 600,
   parameter int BAND_HI_MV = 1200,
   parameter int PAUSE_MV   = 1100,
   parameter int RESUME_MV  = 1400,
   parameter int EXIT_MV    = 2730
) (
   input wire logic        core_clk,      // Clock
   input wire logic        gate_en,       // Gate
   input wire logic [11:0] entry_level,   // Entry level
   input wire logic [11:0] fb_mv,         // Feedback mV
   input wire logic [7:0]  ramp,          // Cycles to limit
   output logic            cs_over_limit, // Over limit
   output bpl_fb_cmp_s     fb_cmp         // Comparators
);
   logic [7:0] on_cnt = 8'h00;

   // Current ramps while on; registered so no loop through gate
   always_ff @(posedge core_clk) on_cnt <= gate_en ? on_cnt + 8'h01 : 8'h00;
   assign cs_over_limit = on_cnt >= ramp;

   // Comparators on the feedback level
   assign fb_cmp = '{below_entry: fb_mv < entry_level, above_resume: fb_mv > RESUME_MV,
                     below_pause: fb_mv <= PAUSE_MV, above_exit: fb_mv > EXIT_MV,
                     above_band_low: fb_mv > BAND_LO_MV, above_band_high: fb_mv > BAND_HI_MV};
endmodule : bpl_plant

// File: bpl_ctrl_tb_top.sv
// Self-checking testbench of the burst and peak limit block
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module bpl_ctrl_tb_top
   import bpl_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        hsel, hwrite, cycle_start, pwm_off, error_amp_above_bias;
   logic        hreadyout, gate_en, prop_comp_reduced, loop_resistor_switch;
   logic        sel_current_en, error_amp_connect, bias_en, cs_over_limit, hresp;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [11:0] fb_mv, burst_peak_limit, entry_level;
   logic [7:0]  ramp;
   bpl_supply_s supply;
   bpl_fb_cmp_s fb_cmp;
   bpl_lim_e    limit_sel;
   int          checks = 0;
   int          miscompares = 0;
   logic [11:0] sense_fb [3] = '{12'h708, 12'h384, 12'h12c};
   logic [11:0] ent_tab [3] = '{12'h406, 12'h3a2, 12'h406};
   bpl_opt_e    opt_tab [3] = '{BPL_OPT_HIGH, BPL_OPT_LOW, BPL_OPT_NONE};

   always #2 core_clk = ~core_clk;

   // Short entry blanking keeps the run brief
   bpl_ctrl #(.ENTRY_BLANK_CYC(16'd20)) bpl_ctrl_i (
      .core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp(hresp), .hrdata, .cycle_start, .pwm_off,
      .cs_over_limit, .fb_cmp, .supply, .error_amp_above_bias, .gate_en, .limit_sel,
      .prop_comp_reduced, .burst_peak_limit, .entry_level, .loop_resistor_switch,
      .sel_current_en, .error_amp_connect, .bias_en);
   bpl_plant bpl_plant_i (.core_clk, .gate_en, .entry_level, .fb_mv, .ramp,
      .cs_over_limit, .fb_cmp);

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   // Bounded wait for the bus ready
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         give_verdict();
      end
   endtask : wait_rdy

   // One single AHB word transfer, entered just after an edge
   task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask : ahb

   // One switching period of 200 edges; counts gate-on cycles
   // Burst keeps its own limit for the whole pulse, so the late check follows it
   task automatic pulse(input logic [7:0] r, input int exp_hi, input bpl_lim_e exp_lim);
      int       hi;
      bpl_lim_e late_lim;
      hi = 0;
      late_lim = (exp_lim == BPL_LIM_BURST) ? BPL_LIM_BURST : BPL_LIM_HIGH_DUTY;
      ramp <= r;
      cycle_start <= 1'b1;
      tick(1);
      cycle_start <= 1'b0;
      for (int k = 1; k < 200; k++) begin
         @(negedge core_clk);
         if (gate_en === 1'b1) hi++;
         if (k == 30) `CHK("lim_early", exp_lim, limit_sel)
         if (k == 85 && exp_hi > 85) `CHK("lim_late", late_lim, limit_sel)
         @(posedge core_clk);
      end
      `CHK("gate_cycles", exp_hi, hi)
   endtask : pulse

   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, cycle_start, pwm_off} = '0;
      {fb_mv, supply, error_amp_above_bias} = '0;
      hsize = 3'h2;
      ramp = 8'hff;
      for (int i = 0; i < 3; i++) begin
         rstn <= 1'b0;
         supply <= 2'b00;
         fb_mv <= sense_fb[i];
         error_amp_above_bias <= (i != 1);
         tick(6);
         rstn <= 1'b1;
         @(negedge core_clk);
         `CHK("entry_rst", 12'h406, entry_level)
         `CHK("loop_rst", 1'b1, loop_resistor_switch)
         tick(1);
         supply <= 2'b10;
         tick(3);
         @(negedge core_clk);
         `CHK("sel_on", 1'b1, sel_current_en)
         `CHK("loop_off", 1'b0, loop_resistor_switch)
         tick(1);
         supply <= 2'b11;
         tick(2);
         @(negedge core_clk);
         `CHK("sel_off", 1'b0, sel_current_en)
         `CHK("amp_link", i != 1, error_amp_connect)
         `CHK("entry", ent_tab[i], entry_level)
         tick(1);
         fb_mv <= 12'h7d0;
         ahb(1'b1, 32'h04, 32'hffff_ffff, rd);
         ahb(1'b0, 32'h04, 32'h0, rd);
         `CHK("stat", {2'b10, 2'b00, i == 1, opt_tab[i]}, rd[6:0])
         `CHK("hresp", 1'b0, hresp)
         if (i == 0) begin
            ahb(1'b0, 32'h00, 32'h0, rd);
            `CHK("ctrl_rst", 32'h0000_0003, rd)
            ahb(1'b0, 32'h0c, 32'h0, rd);
            `CHK("tper_rst", 16'hffff, rd[15:0])
            ahb(1'b0, 32'h40, 32'h0, rd);
            `CHK("unmapped", 32'h0, rd)
            // Switched-off period first, so the curve sees a real last period
            ahb(1'b1, 32'h00, 32'h0000_0002, rd);
            pulse(8'd10, 0, BPL_LIM_LOW_DUTY);
            ahb(1'b1, 32'h00, 32'h0000_0003, rd);
            pulse(8'd10, 55, BPL_LIM_LOW_DUTY);
            pulse(8'd56, 56, BPL_LIM_LOW_DUTY);
            pulse(8'd90, 90, BPL_LIM_LOW_DUTY);
            ahb(1'b1, 32'h00, 32'hffff_fffe, rd);
            pulse(8'd90, 0, BPL_LIM_LOW_DUTY);
            ahb(1'b0, 32'h08, 32'h0, rd);
            `CHK("ton_last", 16'd90, rd[15:0])
            ahb(1'b0, 32'h0c, 32'h0, rd);
            `CHK("tper_last", 16'd202, rd[15:0])
         end
         if (i == 1) begin
            fb_mv <= 12'h384;
            tick(10);
            @(negedge core_clk);
            `CHK("no_burst_yet", 1'b0, prop_comp_reduced)
            tick(20);
            @(negedge core_clk);
            `CHK("burst", 1'b1, prop_comp_reduced)
            `CHK("bias_pause", 1'b0, bias_en)
            `CHK("burst_lim", BPL_LIM_BURST, limit_sel)
            `CHK("burst_mv", 12'h0dc, burst_peak_limit)
            tick(1);
            fb_mv <= 12'h5dc;
            tick(2);
            @(negedge core_clk);
            `CHK("bias_resume", 1'b1, bias_en)
            tick(1);
            pulse(8'hff, 199, BPL_LIM_BURST);
            fb_mv <= 12'h3e8;
            tick(2);
            @(negedge core_clk);
            `CHK("bias_stop", 1'b0, bias_en)
            `CHK("gate_stop", 1'b0, gate_en)
            tick(1);
            fb_mv <= 12'haf0;
            @(negedge core_clk);
            `CHK("exit_lim", 1'b0, limit_sel[1])
            tick(2);
            @(negedge core_clk);
            `CHK("exit", 1'b0, prop_comp_reduced)
         end
         if (i == 2) begin
            fb_mv <= 12'h12c;
            tick(40);
            @(negedge core_clk);
            `CHK("opt1_none", 1'b0, prop_comp_reduced)
         end
         tick(1);
      end
      give_verdict();
   end
endmodule : bpl_ctrl_tb_top
